// ===== hdl/mdds_top.sv
// address generation and dump sequencing for the measurement RAMs
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mdds_map.svh"
module mdds_top (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic meas_write_pulse_in,
    input wire logic dump_step_clk_in,
    input wire logic [15:0] count_hw_bus_in,
    output logic [15:0] count_hw_bus_out,
    output logic count_hw_bus_oe_out,
    output logic [12:0] ram_addr_out,
    output logic ram_write_n_out,
    output logic addr_full_flag_out,
    output logic ram_term_count_out,
    output logic block_done_irq_n_out,
    output logic [7:0] dump_select_out,
    output logic dump_wrap_advance_out,
    output logic dump_count_enable_out,
    output logic meas_active_n_out,
    output logic clk_gate_out,
    output logic hw_reset_out
);

    // three-stage sampler: shift, accept when last two agree
    function automatic logic agree(input logic [2:0] s, input logic old);
        agree = (s[1] == s[2]) ? s[2] : old;
    endfunction

    logic [2:0] wr_sync;
    logic [2:0] step_sync;
    logic [15:0] bus_s1;
    logic [15:0] bus_s2;
    logic [15:0] bus_s3;
    logic wr_lvl;
    logic step_lvl;
    logic [15:0] bus_lvl;
    logic [2:0] next_wr_sync;
    logic [2:0] next_step_sync;
    logic next_wr_lvl;
    logic next_step_lvl;
    logic [15:0] next_bus_lvl;
    logic wr_rise;
    logic step_rise;

    // pin sampling
    always_comb
    begin
        next_wr_sync = {wr_sync[1:0], meas_write_pulse_in};
        next_step_sync = {step_sync[1:0], dump_step_clk_in};
        next_wr_lvl = agree(wr_sync, wr_lvl);
        next_step_lvl = agree(step_sync, step_lvl);
        next_bus_lvl = (bus_s2 == bus_s3) ? bus_s3 : bus_lvl;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_sync <= 3'h7;
            step_sync <= 3'h0;
            bus_s1 <= 16'h0000;
            bus_s2 <= 16'h0000;
            bus_s3 <= 16'h0000;
            wr_lvl <= 1'b1;
            step_lvl <= 1'b0;
            bus_lvl <= 16'h0000;
        end
        else
        begin
            wr_sync <= next_wr_sync;
            step_sync <= next_step_sync;
            bus_s1 <= count_hw_bus_in;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            wr_lvl <= next_wr_lvl;
            step_lvl <= next_step_lvl;
            bus_lvl <= next_bus_lvl;
        end
    end

    // single-cycle edge events
    assign wr_rise = next_wr_lvl & ~wr_lvl;
    assign step_rise = next_step_lvl & ~step_lvl;

    logic wr_hit;
    logic ctrl_hit;
    logic load_hit;
    logic dump_load_hit;
    logic data_hit;

    // register decode
    always_comb
    begin
        wr_hit = wr_in & ~rd_in;
        load_hit = wr_hit && addr_in == `MDDS_REG_LOAD_ADDR;
        ctrl_hit = wr_hit && addr_in == `MDDS_REG_CTRL;
        dump_load_hit = wr_hit && addr_in == `MDDS_REG_DUMP_LOAD;
        data_hit = wr_hit && addr_in == `MDDS_REG_LOCAL_DATA;
    end

    mdds_pkg::mdds_ctrl_t ctrl;
    mdds_pkg::mdds_ctrl_t next_ctrl;
    logic [15:0] local_data;
    logic [15:0] next_local_data;

    // control word latches and local data word
    always_comb
    begin
        next_ctrl = ctrl;
        next_local_data = local_data;
        if (ctrl_hit)
        begin
            next_ctrl = mdds_pkg::mdds_ctrl_t'(wdata_in);
        end
        if (data_hit)
        begin
            next_local_data = wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctrl <= mdds_pkg::mdds_ctrl_t'(`MDDS_CTRL_RESET);
            local_data <= 16'h0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            local_data <= next_local_data;
        end
    end

    mdds_pkg::mdds_load_t ld_state;
    mdds_pkg::mdds_load_t next_ld_state;
    logic [15:0] addr_cnt;
    logic [15:0] next_addr_cnt;
    logic [12:0] addr_latch;
    logic [12:0] next_addr_latch;
    logic [15:0] load_word;
    logic [15:0] next_load_word;
    logic full;
    logic next_full;
    logic term;
    logic next_term;
    logic wrap_adv;
    logic advance;

    // address load sequence, write advance and full detection
    always_comb
    begin
        next_ld_state = ld_state;
        next_addr_cnt = addr_cnt;
        next_addr_latch = addr_latch;
        next_load_word = load_word;
        next_term = term;
        advance = (wr_rise | wrap_adv) && ld_state == mdds_pkg::MDDS_LD_IDLE;
        case (ld_state)
            mdds_pkg::MDDS_LD_IDLE:
            begin
                if (load_hit)
                begin
                    next_load_word = (wdata_in & `MDDS_LOAD_LOW_MASK)
                        | `MDDS_LOAD_TOP_BITS;
                    next_ld_state = mdds_pkg::MDDS_LD_LATCH;
                    next_term = 1'b0;
                end
                else if (advance)
                begin
                    next_addr_latch = addr_cnt[12:0];
                    next_addr_cnt = full ? addr_cnt : addr_cnt + 16'h0001;
                end
            end
            mdds_pkg::MDDS_LD_LATCH:
            begin
                next_addr_latch = load_word[12:0];
                next_addr_cnt = load_word;
                next_ld_state = mdds_pkg::MDDS_LD_COUNT;
            end
            mdds_pkg::MDDS_LD_COUNT:
            begin
                next_addr_cnt = addr_cnt + 16'h0001;
                next_ld_state = mdds_pkg::MDDS_LD_IDLE;
            end
            default:
            begin
                next_ld_state = mdds_pkg::MDDS_LD_IDLE;
            end
        endcase
        next_full = (next_addr_cnt == `MDDS_ADDR_FULL);
        if (advance && ld_state == mdds_pkg::MDDS_LD_IDLE && !load_hit)
        begin
            next_term = full;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ld_state <= mdds_pkg::MDDS_LD_IDLE;
            addr_cnt <= `MDDS_ADDR_RESET;
            addr_latch <= 13'h0000;
            load_word <= `MDDS_ADDR_RESET;
            full <= 1'b0;
            term <= 1'b0;
        end
        else
        begin
            ld_state <= next_ld_state;
            addr_cnt <= next_addr_cnt;
            addr_latch <= next_addr_latch;
            load_word <= next_load_word;
            full <= next_full;
            term <= next_term;
        end
    end

    logic [2:0] dump_cnt;
    logic [2:0] next_dump_cnt;
    logic tc_dly;
    logic next_tc_dly;
    logic next_wrap_adv;
    logic dump_block;
    logic dump_en;

    // dump counter enable chain
    always_comb
    begin
        dump_block = ~(ctrl.dump_mode_sel & ctrl.meas_active_n)
            | term;
        dump_en = ~dump_block & ~ctrl.cpu_dump_enable_n;
    end

    // dump counter: load, step, wrap
    always_comb
    begin
        next_dump_cnt = dump_cnt;
        next_wrap_adv = 1'b0;
        next_tc_dly = 1'b0;
        if (dump_load_hit || tc_dly)
        begin
            next_dump_cnt = ctrl.dump_init_value;
        end
        else if (dump_cnt == `MDDS_DUMP_TC)
        begin
            next_tc_dly = 1'b1;
        end
        else if (dump_en && step_rise)
        begin
            next_dump_cnt = dump_cnt + 3'h1;
            next_wrap_adv = (next_dump_cnt == `MDDS_DUMP_TC);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dump_cnt <= 3'h0;
            tc_dly <= 1'b0;
            wrap_adv <= 1'b0;
        end
        else
        begin
            dump_cnt <= next_dump_cnt;
            tc_dly <= next_tc_dly;
            wrap_adv <= next_wrap_adv;
        end
    end

    mdds_pkg::mdds_stat_t stat;
    logic [15:0] next_rdata;
    logic [7:0] next_select;
    logic next_oe;

    // readback, select decode and bus buffer
    always_comb
    begin
        stat.dump_count_enable = dump_en;
        stat.dump_block = dump_block;
        stat.ram_term_count = term;
        stat.addr_full_flag = full;
        next_rdata = 16'h0000;
        if (rd_in)
        begin
            case (addr_in)
                `MDDS_REG_ADDR_RB: next_rdata = addr_cnt;
                `MDDS_REG_CTRL: next_rdata = 16'(ctrl);
                `MDDS_REG_STATUS: next_rdata = {9'h000, dump_cnt, 4'(stat)};
                `MDDS_REG_LOCAL_DATA: next_rdata = (ctrl.data_buf_disable || ctrl.count_rw_dir)
                    ? local_data : bus_lvl;
                default: next_rdata = 16'h0000;
            endcase
        end
        next_select = 8'h00;
        if (dump_en && dump_cnt != `MDDS_DUMP_TC)
        begin
            next_select = 8'h01 << dump_cnt;
        end
        next_oe = ctrl.count_rw_dir & ~ctrl.data_buf_disable;
    end

    // output registers
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_out <= 16'h0000;
            count_hw_bus_out <= 16'h0000;
            count_hw_bus_oe_out <= 1'b0;
            ram_addr_out <= 13'h0000;
            ram_write_n_out <= 1'b1;
            addr_full_flag_out <= 1'b0;
            ram_term_count_out <= 1'b0;
            block_done_irq_n_out <= 1'b1;
            dump_select_out <= 8'h00;
            dump_wrap_advance_out <= 1'b0;
            dump_count_enable_out <= 1'b0;
            meas_active_n_out <= 1'b0;
            clk_gate_out <= 1'b0;
            hw_reset_out <= 1'b0;
        end
        else
        begin
            rdata_out <= next_rdata;
            count_hw_bus_out <= local_data;
            count_hw_bus_oe_out <= next_oe;
            ram_addr_out <= next_addr_latch;
            ram_write_n_out <= next_wr_lvl;
            addr_full_flag_out <= next_full;
            ram_term_count_out <= next_term;
            block_done_irq_n_out <= ~next_term;
            dump_select_out <= next_select;
            dump_wrap_advance_out <= next_wrap_adv;
            dump_count_enable_out <= dump_en;
            meas_active_n_out <= next_ctrl.meas_active_n;
            clk_gate_out <= next_ctrl.clk_gate;
            hw_reset_out <= next_ctrl.hw_reset;
        end
    end

endmodule

// ===== hdl/mdds_map.svh
// offsets, fields, reset values and notes for the measurement dma dump sequencer
// Functional notes
// - after start address load, each write pulse clocks latches and advances counter until full
// - counter clock is write pulse combined with load pulse and wrap advance
// - while write pulse low, RAMs at latched address take measurement data
// - write pulse rising edge latches next address, counter advances by one
// - counting continues to terminal count; top stage raises address full flag
// - ram terminal count is full flag delayed one write; interrupt follows it
// - decoded readback drives the 16-bit address counter onto local bus
// - buffer direction follows count read/write direction: high local to count bus
// - buffer disable low during transfers; high isolates count bus from local bus
// - processor strobes control latches; they drive dump, measure, clock, reset controls
// - control word carries 3-bit dump counter initial value
// - dump counter runs only with dump mode set and no measurement running
// - ram terminal count disables the dump counter
// - dump block high forces enable off; low, enable follows processor control
// - dump counter loads on processor load pulse, reset or delayed terminal count
// - all three dump counter bits decode to one RAM and buffer select, none at seven
// - dump step clock advances dump counter by one after each read
// - dump terminal count emits wrap advance, stepping address counters
// - delayed dump terminal count reloads initial value; cycle repeats
// - time interval dump: four low, five high, six interpolator, seven reloads
// - load word: low 13 bits first address, upper three bits high
// - after load, counters hold one more than the latches
`ifndef MDDS_MAP_SVH
`define MDDS_MAP_SVH
`define MDDS_REG_LOAD_ADDR 3'h0
`define MDDS_REG_CTRL 3'h1
`define MDDS_REG_DUMP_LOAD 3'h2
`define MDDS_REG_ADDR_RB 3'h3
`define MDDS_REG_STATUS 3'h4
`define MDDS_REG_LOCAL_DATA 3'h5
`define MDDS_LOAD_TOP_BITS 16'hE000
`define MDDS_LOAD_LOW_MASK 16'h1FFF
`define MDDS_ADDR_FULL 16'hFFFF
`define MDDS_DUMP_TC 3'h7
`define MDDS_CTRL_RESET 16'h0000
`define MDDS_ADDR_RESET 16'h0000
`endif

// ===== hdl/mdds_pkg.sv
// types for the measurement dma dump sequencer
package mdds_pkg;
    // control word layout, bit 0 at the right
    typedef struct packed {
        logic [5:0] spare;
        logic hw_reset;
        logic clk_gate;
        logic data_buf_disable;
        logic count_rw_dir;
        logic cpu_dump_enable_n;
        logic meas_active_n;
        logic dump_mode_sel;
        logic [2:0] dump_init_value;
    } mdds_ctrl_t;
    // address load sequence
    typedef enum logic [1:0] {
        MDDS_LD_IDLE = 2'b00,
        MDDS_LD_LATCH = 2'b01,
        MDDS_LD_COUNT = 2'b10
    } mdds_load_t;
    // status flags
    typedef struct packed {
        logic dump_count_enable;
        logic dump_block;
        logic ram_term_count;
        logic addr_full_flag;
    } mdds_stat_t;
endpackage

// ===== verif/mdds_props.sv
// concurrent checks on the sequencer pins
`timescale 1ns/1ps
module mdds_props (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic meas_write_pulse_in,
    input wire logic ram_write_n_out,
    input wire logic addr_full_flag_out,
    input wire logic ram_term_count_out,
    input wire logic block_done_irq_n_out,
    input wire logic [7:0] dump_select_out,
    input wire logic dump_wrap_advance_out,
    input wire logic dump_count_enable_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    // write strobe, terminal count and interrupt
    AST_WRITE_LOW: assert property ($fell(meas_write_pulse_in) |-> ##[1:6] !ram_write_n_out)
        else $error("ram write strobe missed a write pulse");
    AST_TERM_AFTER_FULL: assert property ($rose(ram_term_count_out) |-> $past(addr_full_flag_out))
        else $error("terminal count rose without full flag");
    AST_IRQ_ON_TERM: assert property (ram_term_count_out |-> ##[0:1] !block_done_irq_n_out)
        else $error("block interrupt missing at terminal count");
    // dump select decode and wrap, idle read data
    AST_SEL_ONEHOT: assert property ($onehot0(dump_select_out))
        else $error("more than one dump select active");
    AST_SEL_OFF: assert property (!dump_count_enable_out [*2] |-> dump_select_out == 8'h00)
        else $error("dump select active while disabled");
    AST_WRAP_ONE: assert property (dump_wrap_advance_out |=> !dump_wrap_advance_out)
        else $error("wrap advance longer than one cycle");
    AST_WRAP_SEL: assert property (dump_wrap_advance_out |-> ##[0:1] dump_select_out == 8'h00)
        else $error("count seven still selects a set");
    AST_RELOAD: assert property (dump_wrap_advance_out ##1 dump_count_enable_out |-> ##[1:4]
        ($onehot(dump_select_out) || !dump_count_enable_out))
        else $error("dump counter not reloaded after wrap");
    AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    // main scenarios
    COV_WRAP: cover property (dump_wrap_advance_out);
    COV_TERM: cover property ($rose(ram_term_count_out));
    COV_WRITE: cover property ($fell(ram_write_n_out));
endmodule
bind mdds_top mdds_props chk_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .meas_write_pulse_in(meas_write_pulse_in), .ram_write_n_out(ram_write_n_out),
    .addr_full_flag_out(addr_full_flag_out), .ram_term_count_out(ram_term_count_out),
    .block_done_irq_n_out(block_done_irq_n_out), .dump_select_out(dump_select_out),
    .dump_wrap_advance_out(dump_wrap_advance_out), .dump_count_enable_out(dump_count_enable_out));

// ===== verif/mdds_count_hw.sv
// count hardware model: write pulses, dump steps, count bus
`timescale 1ns/1ps
module mdds_count_hw_model (
    input wire logic clk_in,
    input wire logic oe_in,
    output logic write_pulse_out = 1'b1,
    output logic step_out = 1'b0,
    output logic [15:0] bus_out = 16'h5A3C
);
    // fixed word while listening, churn once released
    always @(posedge clk_in)
        bus_out <= oe_in ? ~bus_out : 16'h5A3C;
    // write pulse, low and high phases of 3+ cycles
    task automatic write_once();
        @(posedge clk_in);
        write_pulse_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        write_pulse_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    // dump step clock after each read
    task automatic step_once();
        @(posedge clk_in);
        step_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        step_out <= 1'b0;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
endmodule

// ===== verif/mdds_tb_top.sv
// self-checking bench for the dump sequencer
`timescale 1ns/1ps
module mdds_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] a = 3'h0;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdv, hw_in, hw_out, mdl_bus;
    logic [12:0] ra;
    logic [7:0] sel;
    logic wp, sc, oe, wrn, full, term, irqn, wrap, en, mact, cg, hr;
    int errors = 0;
    int comparisons = 0;
    // clock and count bus level
    always #50 clk = ~clk;
    assign hw_in = oe ? hw_out : mdl_bus;
    mdds_top dut_u (.clk_sys_in(clk), .rstn_in(rstn), .addr_in(a), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdv), .meas_write_pulse_in(wp), .dump_step_clk_in(sc), .count_hw_bus_in(hw_in),
        .count_hw_bus_out(hw_out), .count_hw_bus_oe_out(oe), .ram_addr_out(ra), .ram_write_n_out(wrn),
        .addr_full_flag_out(full), .ram_term_count_out(term), .block_done_irq_n_out(irqn),
        .dump_select_out(sel), .dump_wrap_advance_out(wrap), .dump_count_enable_out(en),
        .meas_active_n_out(mact), .clk_gate_out(cg), .hw_reset_out(hr));
    mdds_count_hw_model mdl_u (.clk_in(clk), .oe_in(oe), .write_pulse_out(wp), .step_out(sc),
        .bus_out(mdl_bus));
    task automatic conclude();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // register bus write and read
    task automatic bw(input logic [2:0] ad, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        a <= ad;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] ad, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        a <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdv, exp);
    endtask
    task automatic t_reset();
        chk({3'h0, ra}, 16'h0000);
        chk({3'h0, irqn, wrn, en, full, term, sel}, 16'h1800);
        rchk(3'h3, 16'h0000);
        rchk(3'h4, 16'h0004);
        $display("test reset done");
    endtask
    task automatic t_write();
        bw(3'h0, 16'h0010);
        cyc(4);
        chk({3'h0, ra}, 16'h0010);
        rchk(3'h3, 16'hE011);
        repeat (2) mdl_u.write_once();
        chk({3'h0, ra}, 16'h0012);
        rchk(3'h3, 16'hE013);
        $display("test write done");
    endtask
    task automatic t_dump();
        bw(3'h0, 16'h0100);
        bw(3'h1, 16'h001C);
        bw(3'h2, 16'h0000);
        cyc(1);
        repeat (20)
            if (en !== 1'b1)
                cyc(1);
        chk({15'h0, en}, 16'h0001);
        if (en !== 1'b1)
            conclude();
        cyc(2);
        chk({8'h0, sel}, 16'h0010);
        mdl_u.step_once();
        chk({8'h0, sel}, 16'h0020);
        mdl_u.step_once();
        chk({8'h0, sel}, 16'h0040);
        mdl_u.step_once();
        cyc(3);
        chk({8'h0, sel}, 16'h0010);
        chk({3'h0, ra}, 16'h0101);
        rchk(3'h3, 16'hE102);
        bw(3'h1, 16'h000C);
        mdl_u.step_once();
        rchk(3'h4, 16'h0044);
        $display("test dump done");
    endtask
    task automatic t_enable();
        logic [15:0] cw [4] = '{16'h001C, 16'h003C, 16'h0014, 16'h000C};
        logic [1:0] ex [4] = '{2'h3, 2'h2, 2'h2, 2'h0};
        for (int i = 0; i < 4; i++)
        begin
            bw(3'h1, cw[i]);
            cyc(2);
            chk({14'h0, mact, en}, {14'h0, ex[i]});
        end
        $display("test enable done");
    endtask
    task automatic t_full();
        bw(3'h0, 16'h1FFE);
        cyc(5);
        chk({14'h0, full, term}, 16'h0002);
        mdl_u.write_once();
        chk({13'h0, full, term, irqn}, 16'h0006);
        chk({3'h0, ra}, 16'h1FFF);
        bw(3'h1, 16'h001C);
        cyc(2);
        chk({15'h0, en}, 16'h0000);
        mdl_u.write_once();
        rchk(3'h3, 16'hFFFF);
        $display("test full done");
    endtask
    task automatic t_bus();
        bw(3'h1, 16'h0340);
        bw(3'h5, 16'hA5C3);
        cyc(2);
        chk({12'h0, cg, hr, oe, mact}, 16'h000E);
        chk(hw_out, 16'hA5C3);
        bw(3'h1, 16'h00C0);
        cyc(2);
        chk({15'h0, oe}, 16'h0000);
        bw(3'h1, 16'h0000);
        cyc(6);
        rchk(3'h5, 16'h5A3C);
        rchk(3'h7, 16'h0000);
        $display("test bus done");
    endtask
    // reset, scenarios, verdict
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        cyc(5);
        t_reset();
        t_write();
        t_dump();
        t_enable();
        t_full();
        t_bus();
        // mid-run reset, state must clear again
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        cyc(5);
        t_reset();
        conclude();
    end
endmodule
